// ==== mbso_mem_model.sv ====
// Behavioural model of the store buffer and memory side facing the ordering unit.
// Assumes requests arrive as one-cycle pulses on the core clock; the bench can hold it busy.
`timescale 1ns/10ps

module mbso_mem_model
    import mbso_pkg::*;
#(
    parameter int DRAIN = 4,
    parameter int LAT   = 3
)
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // Requests from the unit, and the address of the op offered to it
    input  wire logic            mem_req_valid,
    input  wire logic            mem_req_store,
    input  wire logic [VA_W-1:0] mem_req_va,
    input  wire logic [VA_W-1:0] op_addr,
    // Stall controls from the bench
    input  wire logic            sb_hold,
    input  wire logic            mem_hold,
    // Status back to the unit
    output logic                 sb_empty,
    output logic                 sb_addr_hit,
    output logic                 mem_idle
);
    int              pend;
    int              tmr;
    int              busy;
    logic [VA_W-1:0] last_va;

    // A held buffer keeps its entries, so a stall never loses a store.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend <= 0;
            tmr <= 0;
            busy <= 0;
            last_va <= '0;
        end
        else
        begin
            if (mem_req_valid && mem_req_store)
                last_va <= mem_req_va;
            tmr <= (pend != 0 && !sb_hold && tmr != DRAIN) ? tmr + 1 : 0;
            pend <= pend + int'(mem_req_valid && mem_req_store) - int'(tmr == DRAIN && !sb_hold);
            busy <= (mem_req_valid && !mem_req_store) ? LAT : (busy != 0 ? busy - 1 : 0);
        end
    end

    assign sb_empty    = !sb_hold && pend == 0;
    assign mem_idle    = !mem_hold && busy == 0;
    assign sb_addr_hit = pend != 0 && op_addr[VA_W-1:BLK_LSB] == last_va[VA_W-1:BLK_LSB];
endmodule

// ==== mbso_pkg.sv ====
// Constants and types for the load/store ordering unit of one virtual processor.
// Assumes the issue pipeline, store buffer and MMU are driven from the same core clock.
package mbso_pkg;

    localparam int VA_W  = 64;
    localparam int ASI_W = 8;
    localparam int MSK_W = 7;
    localparam int BLK_LSB = 3;

    // Ordering part of the barrier mask field.
    localparam int ORD_LL = 0;
    localparam int ORD_SL = 1;
    localparam int ORD_LS = 2;
    localparam int ORD_SS = 3;
    // Completion part of the barrier mask field.
    localparam int CMP_LOOK  = 4;
    localparam int CMP_ISSUE = 5;
    localparam int CMP_SYNC  = 6;

    // Nofault address space identifiers, primary/secondary in both byte orders.
    localparam logic [7:0] ASI_PNF  = 8'h82;
    localparam logic [7:0] ASI_SNF  = 8'h83;
    localparam logic [7:0] ASI_PNFL = 8'h8A;
    localparam logic [7:0] ASI_SNFL = 8'h8B;

    localparam logic [MSK_W-1:0] MASK_RST = 7'h00;

    typedef enum logic [2:0] {
        MBSO_OP_OTHER   = 3'h0,
        MBSO_OP_LOAD    = 3'h1,
        MBSO_OP_STORE   = 3'h2,
        MBSO_OP_ATOMIC  = 3'h3,
        MBSO_OP_FLUSH   = 3'h4,
        MBSO_OP_BARRIER = 3'h5
    } mbso_op_t;

    typedef enum logic [1:0] {
        MBSO_IDLE  = 2'h0,
        MBSO_WAIT  = 2'h1,
        MBSO_FLUSH = 2'h3
    } mbso_state_t;

endpackage

// ==== mbso_unit.sv ====
// Load/store ordering unit: sequencing and ordering barriers, fetch-synchronizing
// flush, nonfaulting load checks and store-buffer merge decisions.
// Assumes the MMU accepts a request every cycle and the status inputs are registered.
`timescale 1ns/10ps

module mbso_unit
    import mbso_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Instruction from the issue pipeline
    input  wire logic             op_valid,
    input  wire mbso_op_t         op_kind,
    input  wire logic [VA_W-1:0]  op_addr,
    input  wire logic [ASI_W-1:0] op_asi,
    input  wire logic [MSK_W-1:0] op_mask,
    output logic                  op_ready,
    // Page attributes of the translation entry for op_addr
    input  wire logic             page_side_effect_bit,
    input  wire logic             page_nofault_only_bit,
    input  wire logic             page_cacheable,
    // Memory system and pipeline status
    input  wire logic             sb_empty,
    input  wire logic             sb_addr_hit,
    input  wire logic             mem_idle,
    input  wire logic             pipe_idle,
    // Configuration
    input  wire logic             lookaside_as_sync,
    input  wire logic             ifetch_coherent,
    // Request to the MMU and store buffer
    output logic                  mem_req_valid,
    output logic [VA_W-1:0]       mem_req_va,
    output logic [ASI_W-1:0]      mem_req_asi,
    output logic                  mem_req_store,
    output logic                  mem_req_merge,
    output logic                  fwd_disable,
    // Fetch synchronization
    output logic                  pipe_flush,
    output logic                  icache_inval,
    output logic [VA_W-1:0]       icache_addr,
    // Data access faults
    output logic                  side_effect_page_fault,
    output logic                  nofault_only_page_fault,
    output logic                  bad_space_id_fault
);

    typedef struct packed {
        mbso_state_t       st;
        logic              rdy;
        mbso_op_t          hkind;
        logic [VA_W-1:0]   haddr;
        logic [ASI_W-1:0]  hasi;
        logic [MSK_W-1:0]  hmask;
        logic              hse;
        logic              hcach;
        logic              last_v;
        logic [VA_W-1:3]   last_blk;
        logic              last_nc;
        logic              req_v;
        logic [VA_W-1:0]   req_va;
        logic [ASI_W-1:0]  req_asi;
        logic              req_st;
        logic              req_mg;
        logic              fwd_off;
        logic              pflush;
        logic              iinv;
        logic [VA_W-1:0]   iaddr;
        logic              f_se;
        logic              f_nfo;
        logic              f_asi;
    } mbso_regs_t;

    mbso_regs_t s_q;
    mbso_regs_t s_d;

    logic             accept;
    logic             nf_asi;
    logic             is_mem;
    logic             is_wr;
    logic             flt_se;
    logic             flt_nfo;
    logic             flt_asi;
    logic [MSK_W-1:0] eff_mask;
    logic             sync_ok;
    logic             wait_ok;

    // Issue helper inputs, chosen between the live and the held operation.
    logic             iss;
    mbso_op_t         i_kind;
    logic [VA_W-1:0]  i_addr;
    logic [ASI_W-1:0] i_asi;
    logic             i_se;
    logic             i_cach;

    assign accept = op_valid && s_q.rdy && (s_q.st == MBSO_IDLE);
    assign nf_asi = (op_asi == ASI_PNF) || (op_asi == ASI_SNF)
                 || (op_asi == ASI_PNFL) || (op_asi == ASI_SNFL);
    assign is_mem = (op_kind == MBSO_OP_LOAD) || (op_kind == MBSO_OP_STORE)
                 || (op_kind == MBSO_OP_ATOMIC);
    assign is_wr  = (op_kind == MBSO_OP_STORE) || (op_kind == MBSO_OP_ATOMIC);

    assign flt_asi = is_wr && nf_asi;
    assign flt_se  = (op_kind == MBSO_OP_LOAD) && nf_asi && page_side_effect_bit;
    assign flt_nfo = is_mem && page_nofault_only_bit
                  && !((op_kind == MBSO_OP_LOAD) && nf_asi);

    // Lookaside and issue selections may be promoted to a full sync.
    always_comb
    begin
        eff_mask = op_mask;
        if (lookaside_as_sync && (op_mask[CMP_LOOK] || op_mask[CMP_ISSUE]))
        begin
            eff_mask[CMP_SYNC] = 1'b1;
        end
    end

    // Fault flags must have drained to the ports before a sync lets go.
    assign sync_ok = sb_empty && mem_idle && pipe_idle
                  && !s_q.f_se && !s_q.f_nfo && !s_q.f_asi;

    always_comb
    begin
        wait_ok = 1'b1;
        case (s_q.hkind)
            MBSO_OP_BARRIER:
            begin
                // Every selected constraint has to hold at once.
                wait_ok = ((!s_q.hmask[ORD_LL] && !s_q.hmask[ORD_LS]) || mem_idle)
                       && ((!s_q.hmask[ORD_SL] && !s_q.hmask[ORD_SS]) || sb_empty)
                       && (!s_q.hmask[CMP_LOOK] || sb_empty)
                       && (!s_q.hmask[CMP_ISSUE] || (sb_empty && mem_idle))
                       && (!s_q.hmask[CMP_SYNC] || sync_ok);
            end
            MBSO_OP_FLUSH:
            begin
                wait_ok = sb_empty && mem_idle;
            end
            MBSO_OP_LOAD:
            begin
                wait_ok = sb_empty;
            end
            default:
            begin
                wait_ok = 1'b1;
            end
        endcase
    end

    always_comb
    begin
        s_d = s_q;
        s_d.req_v  = 1'b0;
        s_d.pflush = 1'b0;
        s_d.iinv   = 1'b0;
        s_d.f_se   = 1'b0;
        s_d.f_nfo  = 1'b0;
        s_d.f_asi  = 1'b0;
        iss    = 1'b0;
        i_kind = op_kind;
        i_addr = op_addr;
        i_asi  = op_asi;
        i_se   = page_side_effect_bit;
        i_cach = page_cacheable;

        // A drained buffer has nothing left to forward from or merge into.
        if (sb_empty)
        begin
            s_d.fwd_off = 1'b0;
            s_d.last_v  = 1'b0;
        end

        case (s_q.st)
            MBSO_IDLE:
            begin
                if (accept)
                begin
                    s_d.hkind = op_kind;
                    s_d.haddr = op_addr;
                    s_d.hasi  = op_asi;
                    s_d.hmask = eff_mask;
                    s_d.hse   = page_side_effect_bit;
                    s_d.hcach = page_cacheable;
                    if (is_mem && (flt_se || flt_nfo || flt_asi))
                    begin
                        s_d.f_se  = flt_se;
                        s_d.f_nfo = flt_nfo;
                        s_d.f_asi = flt_asi;
                    end
                    else if (op_kind == MBSO_OP_BARRIER)
                    begin
                        if (op_mask[CMP_LOOK])
                        begin
                            s_d.fwd_off = 1'b1;
                        end
                        if (eff_mask[CMP_SYNC])
                        begin
                            s_d.last_v = 1'b0;
                        end
                        if (eff_mask != MASK_RST)
                        begin
                            s_d.st  = MBSO_WAIT;
                            s_d.rdy = 1'b0;
                        end
                    end
                    else if (op_kind == MBSO_OP_FLUSH)
                    begin
                        s_d.st  = MBSO_WAIT;
                        s_d.rdy = 1'b0;
                    end
                    else if ((op_kind == MBSO_OP_LOAD) && s_q.fwd_off && sb_addr_hit)
                    begin
                        s_d.st  = MBSO_WAIT;
                        s_d.rdy = 1'b0;
                    end
                    else if (is_mem)
                    begin
                        iss = 1'b1;
                    end
                end
            end
            MBSO_WAIT:
            begin
                if (wait_ok)
                begin
                    i_kind = s_q.hkind;
                    i_addr = s_q.haddr;
                    i_asi  = s_q.hasi;
                    i_se   = s_q.hse;
                    i_cach = s_q.hcach;
                    if (s_q.hkind == MBSO_OP_FLUSH)
                    begin
                        s_d.st = MBSO_FLUSH;
                    end
                    else
                    begin
                        iss     = (s_q.hkind == MBSO_OP_LOAD);
                        s_d.st  = MBSO_IDLE;
                        s_d.rdy = 1'b1;
                    end
                end
            end
            MBSO_FLUSH:
            begin
                // Cross-processor visibility latency is not tracked here.
                s_d.pflush = 1'b1;
                s_d.iinv   = !ifetch_coherent;
                s_d.iaddr  = {s_q.haddr[VA_W-1:BLK_LSB], 3'h0};
                s_d.st     = MBSO_IDLE;
                s_d.rdy    = 1'b1;
            end
            default:
            begin
                s_d.st  = MBSO_IDLE;
                s_d.rdy = 1'b1;
            end
        endcase

        if (iss)
        begin
            s_d.req_v   = 1'b1;
            s_d.req_va  = i_addr;
            s_d.req_asi = i_asi;
            s_d.req_st  = (i_kind != MBSO_OP_LOAD);
            s_d.req_mg  = 1'b0;
            if (i_kind == MBSO_OP_STORE)
            begin
                s_d.req_mg = s_q.last_v && !i_se
                          && (s_q.last_blk == i_addr[VA_W-1:BLK_LSB])
                          && (s_q.last_nc == !i_cach);
                s_d.last_v   = !i_se;
                s_d.last_blk = i_addr[VA_W-1:BLK_LSB];
                s_d.last_nc  = !i_cach;
            end
            else if (i_kind == MBSO_OP_ATOMIC)
            begin
                s_d.last_v = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s_q     <= '0;
            s_q.st  <= MBSO_IDLE;
            s_q.rdy <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign op_ready                = s_q.rdy;
    assign mem_req_valid           = s_q.req_v;
    assign mem_req_va              = s_q.req_va;
    assign mem_req_asi             = s_q.req_asi;
    assign mem_req_store           = s_q.req_st;
    assign mem_req_merge           = s_q.req_mg;
    assign fwd_disable             = s_q.fwd_off;
    assign pipe_flush              = s_q.pflush;
    assign icache_inval            = s_q.iinv;
    assign icache_addr             = s_q.iaddr;
    assign side_effect_page_fault  = s_q.f_se;
    assign nofault_only_page_fault = s_q.f_nfo;
    assign bad_space_id_fault      = s_q.f_asi;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    logic look_acc;
    logic plain_ld;
    assign look_acc = accept && (op_kind == MBSO_OP_BARRIER) && op_mask[CMP_LOOK];
    assign plain_ld = accept && (op_kind == MBSO_OP_LOAD) && !flt_se && !flt_nfo
                   && !(s_q.fwd_off && sb_addr_hit);

    lookaside_fwd_a: assert property (look_acc |=> fwd_disable)
        else $error("lookaside barrier did not disable forwarding");
    lookaside_hold_a: assert property ((s_q.st == MBSO_WAIT) && (s_q.hkind == MBSO_OP_BARRIER)
        && s_q.hmask[CMP_LOOK] && !sb_empty |=> !op_ready && !mem_req_valid)
        else $error("lookaside barrier released over pending stores");
    issue_wait_a: assert property ((s_q.st == MBSO_WAIT) && (s_q.hkind == MBSO_OP_BARRIER)
        && s_q.hmask[CMP_ISSUE] && !mem_idle |=> !op_ready && !mem_req_valid)
        else $error("issue barrier released with memory busy");
    sync_wait_a: assert property ((s_q.st == MBSO_WAIT) && (s_q.hkind == MBSO_OP_BARRIER)
        && s_q.hmask[CMP_SYNC] && !pipe_idle |=> !op_ready)
        else $error("sync barrier released with pipeline busy");
    sync_promote_a: assert property (accept && (op_kind == MBSO_OP_BARRIER) && lookaside_as_sync
        && op_mask[CMP_ISSUE] |=> s_q.hmask[CMP_SYNC] && !op_ready)
        else $error("issue barrier not promoted to sync");
    flush_pulse_a: assert property ((s_q.st == MBSO_WAIT) && (s_q.hkind == MBSO_OP_FLUSH)
        && sb_empty && mem_idle |=> ##1 pipe_flush && (icache_inval == !$past(ifetch_coherent)))
        else $error("flush did not refill the pipeline");
    se_fault_a: assert property (accept && flt_se |=> side_effect_page_fault && !mem_req_valid)
        else $error("nonfaulting load on side-effect page not faulted");
    nfo_fault_a: assert property (accept && flt_nfo |=> nofault_only_page_fault && !mem_req_valid)
        else $error("normal access to nofault-only page not faulted");
    bad_asi_a: assert property (accept && flt_asi |=> bad_space_id_fault)
        else $error("store with nofault identifier not faulted");
    // A faulted store leaves the last request fields standing, so it is excluded here.
    se_merge_a: assert property (accept && (op_kind == MBSO_OP_STORE) && page_side_effect_bit
        && !flt_nfo && !flt_asi |=> !mem_req_merge)
        else $error("side-effect store merged");
    addr_pass_a: assert property (plain_ld |=> mem_req_valid
        && (mem_req_va == $past(op_addr)) && (mem_req_asi == $past(op_asi)))
        else $error("load address or identifier not presented");

    cover property (look_acc ##[1:20] !fwd_disable);
    cover property (mem_req_valid && mem_req_merge);
    cover property ((s_q.st == MBSO_FLUSH) ##1 pipe_flush);
    cover property (accept && flt_se);

endmodule

// ==== memory_barrier_store_order_tb_top.sv ====
// Self-checking bench for the load/store ordering unit.
// Assumes the store buffer model answers on the same core clock at 25 MHz.
`timescale 1ns/10ps

module memory_barrier_store_order_tb_top
    import mbso_pkg::*;
();
    logic             clk, nrst, op_valid, op_ready, pipe_idle, lookaside_as_sync, ifetch_coherent;
    mbso_op_t         op_kind;
    logic [VA_W-1:0]  op_addr, mem_req_va, icache_addr;
    logic [ASI_W-1:0] op_asi, mem_req_asi;
    logic [MSK_W-1:0] op_mask;
    logic             page_side_effect_bit, page_nofault_only_bit, page_cacheable;
    logic             sb_empty, sb_addr_hit, mem_idle, sb_hold, mem_hold;
    logic             mem_req_valid, mem_req_store, mem_req_merge, fwd_disable, pipe_flush, icache_inval;
    logic             side_effect_page_fault, nofault_only_page_fault, bad_space_id_fault;
    int               num_errors = 0;
    int               cmp_count = 0;

    mbso_unit u_dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_kind(op_kind), .op_addr(op_addr),
        .op_asi(op_asi), .op_mask(op_mask), .op_ready(op_ready), .page_side_effect_bit(page_side_effect_bit),
        .page_nofault_only_bit(page_nofault_only_bit), .page_cacheable(page_cacheable), .sb_empty(sb_empty),
        .sb_addr_hit(sb_addr_hit), .mem_idle(mem_idle), .pipe_idle(pipe_idle),
        .lookaside_as_sync(lookaside_as_sync), .ifetch_coherent(ifetch_coherent),
        .mem_req_valid(mem_req_valid), .mem_req_va(mem_req_va), .mem_req_asi(mem_req_asi),
        .mem_req_store(mem_req_store), .mem_req_merge(mem_req_merge), .fwd_disable(fwd_disable),
        .pipe_flush(pipe_flush), .icache_inval(icache_inval), .icache_addr(icache_addr),
        .side_effect_page_fault(side_effect_page_fault), .nofault_only_page_fault(nofault_only_page_fault),
        .bad_space_id_fault(bad_space_id_fault));

    mbso_mem_model u_mem (.clk(clk), .nrst(nrst), .mem_req_valid(mem_req_valid), .mem_req_store(mem_req_store),
        .mem_req_va(mem_req_va), .op_addr(op_addr), .sb_hold(sb_hold), .mem_hold(mem_hold),
        .sb_empty(sb_empty), .sb_addr_hit(sb_addr_hit), .mem_idle(mem_idle));

    initial
    begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string name, input logic [VA_W-1:0] exp, input logic [VA_W-1:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic step();
        @(posedge clk);
        #1;
    endtask

    // Offers one op and returns in the cycle after the edge that takes it.
    task automatic issue(input mbso_op_t k, input logic [VA_W-1:0] a, input logic [ASI_W-1:0] s,
                         input logic [MSK_W-1:0] m, input logic [2:0] at);
        int n;
        // One idle edge first, so op_valid never drops and rises in one time step.
        step();
        for (n = 0; n < 100 && op_ready !== 1'h1; n++)
            step();
        if (op_ready !== 1'h1)
            chk("ready_wait", 1'h1, op_ready);
        op_valid = 1'h1;
        op_kind = k;
        op_addr = a;
        op_asi = s;
        op_mask = m;
        {page_side_effect_bit, page_nofault_only_bit, page_cacheable} = at;
        step();
        op_valid = 1'h0;
    endtask

    task automatic settle();
        for (int n = 0; n < 200 && !(sb_empty === 1'h1 && mem_idle === 1'h1); n++)
            step();
        if (!(sb_empty === 1'h1 && mem_idle === 1'h1))
            chk("settle_wait", 2'h3, {sb_empty, mem_idle});
    endtask

    task automatic fault_case(input mbso_op_t k, input logic [ASI_W-1:0] s, input logic [2:0] at,
                              input logic [2:0] ef, input logic er);
        issue(k, 64'h0000_0000_0000_0040, s, 7'h00, at);
        chk("faults", ef, {side_effect_page_fault, nofault_only_page_fault, bad_space_id_fault});
        chk("fault_req", er, mem_req_valid);
    endtask

    task automatic st(input logic [VA_W-1:0] a, input logic [2:0] at, input logic em);
        issue(MBSO_OP_STORE, a, 8'h80, 7'h00, at);
        chk("st_req", 2'h3, {mem_req_valid, mem_req_store});
        chk("st_merge", em, mem_req_merge);
    endtask

    // The hold pattern is {pipe busy, memory busy, store buffer busy}.
    task automatic bar(input logic [MSK_W-1:0] m, input logic [2:0] h, input logic stall);
        settle();
        {mem_hold, sb_hold} = h[1:0];
        pipe_idle = !h[2];
        issue(MBSO_OP_BARRIER, '0, 8'h80, m, 3'h0);
        if (m[CMP_LOOK])
            chk("fwd_set", 1'h1, fwd_disable);
        step();
        step();
        chk("bar_stall", !stall, op_ready);
        {pipe_idle, mem_hold, sb_hold} = 3'h4;
        // Stores held back earlier must drain before the barrier can let go.
        settle();
        step();
        chk("bar_free", 1'h1, op_ready);
        chk("fwd_clr", 1'h0, fwd_disable);
    endtask

    initial
    begin
        static logic [ASI_W-1:0] nf_ids [4] = '{ASI_PNF, ASI_SNF, ASI_PNFL, ASI_SNFL};
        {nrst, op_valid, op_addr, op_asi, op_mask} = '0;
        op_kind = MBSO_OP_OTHER;
        {page_side_effect_bit, page_nofault_only_bit, page_cacheable} = 3'h0;
        {pipe_idle, lookaside_as_sync, ifetch_coherent, sb_hold, mem_hold} = 5'h10;
        repeat (8) @(posedge clk);
        #1;
        chk("rst_out", 4'h8, {op_ready, mem_req_valid, pipe_flush, side_effect_page_fault});
        nrst = 1'h1;
        issue(MBSO_OP_LOAD, 64'hFEDC_BA98_7654_3211, 8'h80, 7'h00, 3'h1);
        chk("ld_req", 2'h2, {mem_req_valid, mem_req_store});
        chk("ld_va", 64'hFEDC_BA98_7654_3211, mem_req_va);
        chk("ld_asi", 8'h80, mem_req_asi);
        for (int i = 0; i < 4; i++)
            fault_case(MBSO_OP_LOAD, nf_ids[i], 3'h4, 3'h4, 1'h0);
        fault_case(MBSO_OP_LOAD, 8'h80, 3'h2, 3'h2, 1'h0);
        fault_case(MBSO_OP_STORE, 8'h80, 3'h2, 3'h2, 1'h0);
        fault_case(MBSO_OP_LOAD, ASI_PNFL, 3'h3, 3'h0, 1'h1);
        fault_case(MBSO_OP_STORE, ASI_SNF, 3'h1, 3'h1, 1'h0);
        settle();
        sb_hold = 1'h1;
        st(64'h1000, 3'h1, 1'h0);
        st(64'h1004, 3'h1, 1'h1);
        st(64'h1008, 3'h1, 1'h0);
        st(64'h100C, 3'h0, 1'h0);
        st(64'h100A, 3'h0, 1'h1);
        st(64'h100B, 3'h4, 1'h0);
        st(64'h100D, 3'h0, 1'h0);
        sb_hold = 1'h0;
        bar(7'h40, 3'h1, 1'h1);
        sb_hold = 1'h1;
        st(64'h100E, 3'h0, 1'h0);
        sb_hold = 1'h0;
        bar(7'h00, 3'h7, 1'h0);
        bar(7'h01, 3'h2, 1'h1);
        bar(7'h02, 3'h1, 1'h1);
        bar(7'h04, 3'h2, 1'h1);
        bar(7'h08, 3'h1, 1'h1);
        bar(7'h10, 3'h1, 1'h1);
        bar(7'h20, 3'h2, 1'h1);
        bar(7'h40, 3'h4, 1'h1);
        bar(7'h03, 3'h1, 1'h1);
        bar(7'h41, 3'h4, 1'h1);
        lookaside_as_sync = 1'h1;
        bar(7'h10, 3'h4, 1'h1);
        bar(7'h20, 3'h4, 1'h1);
        lookaside_as_sync = 1'h0;
        for (int c = 0; c < 2; c++)
        begin
            settle();
            ifetch_coherent = 1'(c);
            sb_hold = 1'h1;
            issue(MBSO_OP_FLUSH, 64'h0000_0000_0000_2345, 8'h80, 7'h00, 3'h1);
            step();
            chk("flush_wait", 1'h0, op_ready);
            sb_hold = 1'h0;
            step();
            step();
            chk("flush_pulse", 2'h3, {pipe_flush, op_ready});
            chk("icache_inval", 1'(c == 0), icache_inval);
            if (c == 0)
                chk("icache_addr", 64'h0000_0000_0000_2340, icache_addr);
        end
        test_done();
    end

    initial
    begin
        #(40 * 10000);
        num_errors++;
        test_done();
    end
endmodule
